// ### rtl/mdsp_host.sv
// Controller end of the mixed discrete I/O serial port, with an APB slave.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mdsp_host
  import mdsp_pkg::*;
#(
  parameter logic [7:0] EXP_ID = MDSP_MODULE_ID
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  mdsp_link_if.host        link
);

  typedef enum logic [1:0] {
    MDSP_ST_IDLE  = 2'b00,
    MDSP_ST_RUN   = 2'b01,
    MDSP_ST_DRAIN = 2'b10
  } mdsp_state_e;

  // ***********************************
  // Register bus
  // ***********************************
  mdsp_state_e           state;
  logic [MDSP_N_OUT-1:0] out_img;
  logic [MDSP_N_IN-1:0]  in_img;
  logic [MDSP_IRQ_W-1:0] irq_stat;
  logic [MDSP_IRQ_W-1:0] irq_mask;
  logic [MDSP_IRQ_W-1:0] irq_set;
  logic [MDSP_IRQ_W-1:0] irq_w1c;
  logic [MDSP_IRQ_W-1:0] next_irq_stat;
  logic                  setup_acc;
  logic                  wr_take;
  logic                  mapped;
  logic [31:0]           rd_mux;
  logic                  start;

  assign setup_acc = psel && penable && !pready;
  assign wr_take   = psel && penable && pready && pwrite;
  assign mapped    = paddr inside {MDSP_REG_CTRL, MDSP_REG_OUT_IMG, MDSP_REG_IN_IMG,
                                   MDSP_REG_STATUS, MDSP_REG_IRQ_STAT, MDSP_REG_IRQ_MASK};
  assign start     = wr_take && (paddr == MDSP_REG_CTRL) && pwdata[MDSP_CTRL_START]
                     && (state == MDSP_ST_IDLE);
  assign irq_w1c   = (wr_take && paddr == MDSP_REG_IRQ_STAT) ? pwdata[MDSP_IRQ_W-1:0] : '0;
  assign next_irq_stat = (irq_stat & ~irq_w1c) | irq_set;

  always_comb begin
    rd_mux = '0;
    case (paddr)
      MDSP_REG_OUT_IMG:  rd_mux[MDSP_N_OUT-1:0] = out_img;
      MDSP_REG_IN_IMG:   rd_mux[MDSP_N_IN-1:0]  = in_img;
      MDSP_REG_STATUS:   rd_mux[1:0] = {link.dev_fault, state != MDSP_ST_IDLE};
      MDSP_REG_IRQ_STAT: rd_mux[MDSP_IRQ_W-1:0] = irq_stat;
      MDSP_REG_IRQ_MASK: rd_mux[MDSP_IRQ_W-1:0] = irq_mask;
      default:           rd_mux = '0;
    endcase
  end

  // One wait state keeps every bus output on a flip-flop.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup_acc;
      pslverr <= setup_acc && !mapped;
      prdata  <= (setup_acc && !pwrite) ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_img  <= '0;
      irq_mask <= '0;
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      if (wr_take && paddr == MDSP_REG_OUT_IMG) begin
        out_img <= pwdata[MDSP_N_OUT-1:0];
      end
      if (wr_take && paddr == MDSP_REG_IRQ_MASK) begin
        irq_mask <= pwdata[MDSP_IRQ_W-1:0];
      end
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
    end
  end

  // ***********************************
  // Link sequencer
  // ***********************************
  logic [MDSP_CNT_W-1:0]     tx_slot;
  logic [MDSP_CNT_W-1:0]     nx_slot;
  logic [MDSP_CNT_W-1:0]     rx_slot;
  logic                      rx_valid;
  logic [MDSP_ID_W-1:0]      id_sh;
  logic [MDSP_ID_W-1:0]      next_id;
  logic [MDSP_IN_IMG_W-1:0]  in_sh;
  logic [MDSP_IN_IMG_W-1:0]  next_in;
  logic [MDSP_OUT_IMG_W-1:0] out_byte;
  logic [MDSP_CNT_W-1:0]     tx_off;
  logic [MDSP_CNT_W-1:0]     rx_off;
  logic                      rx_id_done;
  logic                      id_bad;
  logic                      rx_is_out;
  logic                      rx_is_in;
  logic                      echo_bad;
  logic                      fault_q;

  assign out_byte   = {{(MDSP_OUT_IMG_W-MDSP_N_OUT){1'b0}}, out_img};
  assign nx_slot    = tx_slot + MDSP_SLOT_ONE;
  assign tx_off     = nx_slot - MDSP_SLOT_OUT_FIRST;
  assign rx_off     = rx_slot - MDSP_SLOT_OUT_FIRST;
  assign next_id    = {link.dev_to_host, id_sh[MDSP_ID_W-1:1]};
  assign next_in    = {link.dev_to_host, in_sh[MDSP_IN_IMG_W-1:1]};
  assign rx_id_done = rx_valid && rx_slot == MDSP_SLOT_ID_LAST;
  assign id_bad     = rx_id_done && next_id != EXP_ID;
  assign rx_is_out  = rx_valid && rx_slot >= MDSP_SLOT_OUT_FIRST
                      && rx_slot <= MDSP_SLOT_OUT_LAST;
  assign rx_is_in   = rx_valid && rx_slot >= MDSP_SLOT_IN_FIRST;
  assign irq_set[MDSP_IRQ_DONE]   = state == MDSP_ST_DRAIN;
  assign irq_set[MDSP_IRQ_ID_ERR] = id_bad;
  assign irq_set[MDSP_IRQ_ECHO]   = state == MDSP_ST_DRAIN && echo_bad;
  assign irq_set[MDSP_IRQ_FAULT]  = link.dev_fault && !fault_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state            <= MDSP_ST_IDLE;
      tx_slot          <= '0;
      rx_slot          <= '0;
      rx_valid         <= 1'b0;
      link.frame       <= 1'b0;
      link.host_to_dev <= 1'b0;
      id_sh            <= '0;
      in_sh            <= '0;
      in_img           <= '0;
      echo_bad         <= 1'b0;
      fault_q          <= 1'b0;
    end else begin
      fault_q  <= link.dev_fault;
      rx_slot  <= tx_slot;
      rx_valid <= link.frame;
      if (rx_valid && rx_slot <= MDSP_SLOT_ID_LAST) begin
        id_sh <= next_id;
      end
      if (rx_is_in) begin
        in_sh <= next_in;
      end
      if (rx_is_out && link.dev_to_host != out_byte[rx_off[2:0]]) begin
        echo_bad <= 1'b1;
      end
      case (state)
        MDSP_ST_IDLE: begin
          if (start) begin
            state      <= MDSP_ST_RUN;
            tx_slot    <= '0;
            link.frame <= 1'b1;
            echo_bad   <= 1'b0;
          end
        end
        MDSP_ST_RUN: begin
          tx_slot          <= nx_slot;
          link.host_to_dev <= (nx_slot >= MDSP_SLOT_OUT_FIRST && nx_slot <= MDSP_SLOT_OUT_LAST)
                              ? out_byte[tx_off[2:0]] : 1'b0;
          if (id_bad) begin
            state            <= MDSP_ST_IDLE;
            link.frame       <= 1'b0;
            link.host_to_dev <= 1'b0;
          end else if (tx_slot == MDSP_SLOT_IN_LAST) begin
            state            <= MDSP_ST_DRAIN;
            link.frame       <= 1'b0;
            link.host_to_dev <= 1'b0;
          end
        end
        MDSP_ST_DRAIN: begin
          state  <= MDSP_ST_IDLE;
          in_img <= next_in[MDSP_N_IN-1:0];
        end
        default: begin
          state      <= MDSP_ST_IDLE;
          link.frame <= 1'b0;
        end
      endcase
    end
  end

endmodule : mdsp_host
`default_nettype wire

// ### rtl/mdsp_pkg.sv
// Shared constants for the mixed discrete I/O serial port and its controller.
package mdsp_pkg;
  // ***********************************
  // Image layout
  // ***********************************
  localparam int MDSP_N_IN     = 10;
  localparam int MDSP_N_OUT    = 6;
  localparam int MDSP_IN_IMG_W = 16;
  localparam int MDSP_OUT_IMG_W = 8;
  localparam int MDSP_ID_W     = 8;
  // Module type identifier: the value is arbitrary.
  localparam logic [7:0] MDSP_MODULE_ID = 8'h5A;
  // ***********************************
  // Frame slots, one bit per clk_sys cycle
  // ***********************************
  localparam int MDSP_CNT_W = 6;
  localparam logic [5:0] MDSP_SLOT_ID_FIRST  = 6'h00;
  localparam logic [5:0] MDSP_SLOT_ID_LAST   = 6'h07;
  localparam logic [5:0] MDSP_SLOT_GAP       = 6'h08;
  localparam logic [5:0] MDSP_SLOT_OUT_FIRST = 6'h09;
  localparam logic [5:0] MDSP_SLOT_OUT_LAST  = 6'h10;
  localparam logic [5:0] MDSP_SLOT_IN_FIRST  = 6'h11;
  localparam logic [5:0] MDSP_SLOT_IN_LAST   = 6'h20;
  localparam logic [5:0] MDSP_SLOT_ONE       = 6'h01;
  // ***********************************
  // Controller register map
  // ***********************************
  localparam logic [7:0] MDSP_REG_CTRL     = 8'h00;
  localparam logic [7:0] MDSP_REG_OUT_IMG  = 8'h04;
  localparam logic [7:0] MDSP_REG_IN_IMG   = 8'h08;
  localparam logic [7:0] MDSP_REG_STATUS   = 8'h0C;
  localparam logic [7:0] MDSP_REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] MDSP_REG_IRQ_MASK = 8'h14;
  localparam int MDSP_CTRL_START = 0;
  localparam int MDSP_IRQ_W      = 4;
  localparam int MDSP_IRQ_DONE   = 0;
  localparam int MDSP_IRQ_ID_ERR = 1;
  localparam int MDSP_IRQ_ECHO   = 2;
  localparam int MDSP_IRQ_FAULT  = 3;
endpackage : mdsp_pkg

// ### rtl/mdsp_link_if.sv
// Serial link between the controller and the discrete I/O module.
`timescale 1ns/1ps
`default_nettype none
interface mdsp_link_if;
  logic frame;
  logic host_to_dev;
  logic dev_to_host;
  logic dev_fault;
  modport dev (
    input  frame,
    input  host_to_dev,
    output dev_to_host,
    output dev_fault
  );
  modport host (
    output frame,
    output host_to_dev,
    input  dev_to_host,
    input  dev_fault
  );
endinterface : mdsp_link_if
`default_nettype wire

// ### rtl/mdsp_device.sv
// Module end of the mixed discrete I/O serial port.
// Summary of operation
// - Ten inputs, six outputs, one common return.
// - Overcurrent or short forces that output off.
// - Any output fault raises module fault line.
// - Fault latched until monitor clear or power cycle.
// - Output indicator green when on, orange faulted.
// - Input indicator green while input voltage present.
// - Green indicators work without user power.
// - Power indicator green with logic and user power.
// - Input image two bytes, output image one.
// - Controller exchanges images in whole bytes.
// - Controller checks identifier before exchanging data.
// - Identifier, inputs, outputs all travel serially.
// - Received output bits echoed back for verification.
// - Output bits deserialised, input states serialised.
`timescale 1ns/1ps
`default_nettype none
module mdsp_device
  import mdsp_pkg::*;
#(
  parameter int N_IN  = MDSP_N_IN,
  parameter int N_OUT = MDSP_N_OUT
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  mdsp_link_if.dev              link,
  input  wire logic [N_IN-1:0]  in_pins,
  input  wire logic [N_OUT-1:0] out_overcurrent,
  input  wire logic             monitor_clear,
  input  wire logic             user_pwr_ok,
  output logic      [N_OUT-1:0] out_drive,
  output logic      [N_IN-1:0]  led_in_green,
  output logic      [N_OUT-1:0] led_out_green,
  output logic      [N_OUT-1:0] led_out_orange,
  output logic                  power_indicator
);

  // ***********************************
  // Parameter checks
  // ***********************************
  if (N_IN != MDSP_N_IN || N_OUT != MDSP_N_OUT) begin : g_chk
    $error("Channel counts must match the image layout.");
  end

  // ***********************************
  // Slot decode
  // ***********************************
  function automatic logic in_range(input logic [5:0] v, input logic [5:0] lo,
                                    input logic [5:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  logic [MDSP_CNT_W-1:0]     slot;
  logic [MDSP_CNT_W-1:0]     next_slot;
  logic                      is_id;
  logic                      is_out;
  logic                      is_in;
  logic                      is_gap;
  logic                      out_done;
  logic [MDSP_CNT_W-1:0]     in_off;
  logic [MDSP_OUT_IMG_W-1:0] out_shift;
  logic [MDSP_OUT_IMG_W-1:0] next_out_shift;
  logic [MDSP_IN_IMG_W-1:0]  in_snap;
  logic [MDSP_IN_IMG_W-1:0]  in_image;
  logic [N_OUT-1:0]          cmd;
  logic [N_OUT-1:0]          fault;
  logic [N_OUT-1:0]          next_fault;
  logic [N_OUT-1:0]          on_now;
  logic                      fault_clear;
  logic                      id_bit;
  logic                      in_bit;
  logic                      next_tx;

  assign is_id    = link.frame && in_range(slot, MDSP_SLOT_ID_FIRST, MDSP_SLOT_ID_LAST);
  assign is_gap   = link.frame && (slot == MDSP_SLOT_GAP);
  assign is_out   = link.frame && in_range(slot, MDSP_SLOT_OUT_FIRST, MDSP_SLOT_OUT_LAST);
  assign is_in    = link.frame && in_range(slot, MDSP_SLOT_IN_FIRST, MDSP_SLOT_IN_LAST);
  assign out_done = link.frame && (slot == MDSP_SLOT_OUT_LAST);
  assign in_off   = slot - MDSP_SLOT_IN_FIRST;
  assign next_slot = link.frame ? slot + MDSP_SLOT_ONE : '0;

  // ***********************************
  // Slot counter
  // ***********************************
  // The counter restarts whenever the frame line drops, so an aborted frame
  // leaves no partial state behind.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot <= '0;
    end else begin
      slot <= next_slot;
    end
  end

  // ***********************************
  // Output image, serial to parallel
  // ***********************************
  assign next_out_shift = {link.host_to_dev, out_shift[MDSP_OUT_IMG_W-1:1]};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_shift <= '0;
    end else if (is_out) begin
      out_shift <= next_out_shift;
    end
  end

  // The two top bits of the byte are dropped, so only the six channels move.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd <= '0;
    end else if (out_done) begin
      cmd <= next_out_shift[N_OUT-1:0];
    end
  end

  // ***********************************
  // Input image, parallel to serial
  // ***********************************
  assign in_image = {{(MDSP_IN_IMG_W-N_IN){1'b0}}, in_pins};

  // A snapshot keeps the two input bytes coherent while they are shifted.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_snap <= '0;
    end else if (is_gap) begin
      in_snap <= in_image;
    end
  end

  assign id_bit = MDSP_MODULE_ID[slot[2:0]];
  assign in_bit = in_snap[in_off[3:0]];

  always_comb begin
    next_tx = 1'b0;
    if (is_id) begin
      next_tx = id_bit;
    end else if (is_out) begin
      next_tx = link.host_to_dev;
    end else if (is_in) begin
      next_tx = in_bit;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.dev_to_host <= 1'b0;
    end else begin
      link.dev_to_host <= next_tx;
    end
  end

  // ***********************************
  // Output protection
  // ***********************************
  // Loss of user power counts as a power cycle on the user side. A new fault
  // in the same cycle as a clear is kept.
  assign fault_clear = monitor_clear || !user_pwr_ok;
  assign next_fault  = (fault & ~{N_OUT{fault_clear}}) | (out_overcurrent & cmd);
  assign on_now      = cmd & ~next_fault;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault <= '0;
    end else begin
      fault <= next_fault;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_drive <= '0;
    end else begin
      out_drive <= on_now;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.dev_fault <= 1'b0;
    end else begin
      link.dev_fault <= |next_fault;
    end
  end

  // ***********************************
  // Indicators
  // ***********************************
  // Green states are not gated by user power, since they run on logic power.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      led_out_green  <= '0;
      led_out_orange <= '0;
    end else begin
      led_out_green  <= on_now;
      led_out_orange <= next_fault;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      led_in_green <= '0;
    end else begin
      led_in_green <= in_pins;
    end
  end

  // Logic power is present whenever this logic runs.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_indicator <= 1'b0;
    end else begin
      power_indicator <= user_pwr_ok;
    end
  end

endmodule : mdsp_device
`default_nettype wire

// ### testbench/mdsp_sva.sv
// Concurrent checks on the serial link between the controller and the module.
`timescale 1ns/1ps
`default_nettype none
module mdsp_sva
  import mdsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic frame,
  input wire logic host_to_dev,
  input wire logic dev_to_host,
  input wire logic dev_fault
);
  // ********************
  // Slot counter
  // ********************
  // Counting slots keeps each check to one line, with no long unrolled sequences.
  logic [5:0] slot;
  logic [5:0] next_slot;
  assign next_slot = frame ? slot + MDSP_SLOT_ONE : 6'h00;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slot <= 6'h00;
    end else begin
      slot <= next_slot;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence id_phase;
    frame [*8];
  endsequence
  sequence frame_open;
    $rose(frame);
  endsequence
  reset_quiet_a: assert property ($fell(rst) |-> !frame && !dev_to_host && !dev_fault)
    else $error("link not idle after reset");
  id_first_a: assert property (frame_open |-> ##1 id_phase)
    else $error("frame ended inside identifier phase");
  id_bits_a: assert property (frame && slot >= 6'h01 && slot <= 6'h08
    |-> dev_to_host == MDSP_MODULE_ID[slot - 6'h01]) else $error("identifier bit wrong");
  id_accept_a: assert property (slot == 6'h09 |-> frame)
    else $error("matching identifier rejected");
  echo_match_a: assert property (frame && slot >= 6'h0A && slot <= 6'h11
    |-> dev_to_host == $past(host_to_dev)) else $error("output echo wrong");
  out_unused_a: assert property (frame && (slot == 6'h0F || slot == 6'h10) |-> !host_to_dev)
    else $error("unused output bit sent as one");
  host_idle_a: assert property (frame && slot >= 6'h11 |-> !host_to_dev)
    else $error("controller line busy during input phase");
  in_unused_a: assert property (slot >= 6'h1C && slot <= 6'h21 |-> !dev_to_host)
    else $error("unused input bit sent as one");
  frame_len_a: assert property ($fell(frame) |-> slot == 6'h21 || slot == 6'h09)
    else $error("frame length wrong");
endmodule : mdsp_sva
`default_nettype wire

// ### testbench/mixed_discrete_io_serial_port_tb.sv
// Self-checking bench joining controller and module over the serial link.
`timescale 1ns/1ps
`default_nettype none
module mixed_discrete_io_serial_port_tb
  import mdsp_pkg::*;
;
  logic        clk_sys         = 1'b0;
  logic        rst             = 1'b1;
  logic [7:0]  paddr           = 8'h00;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [31:0] pwdata          = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [9:0]  in_pins         = 10'h000;
  logic [5:0]  out_overcurrent = 6'h00;
  logic        monitor_clear   = 1'b0;
  logic        user_pwr_ok     = 1'b1;
  logic [5:0]  out_drive;
  logic [9:0]  led_in_green;
  logic [5:0]  led_out_green;
  logic [5:0]  led_out_orange;
  logic        power_indicator;
  logic [31:0] rdata;
  logic        err;
  int          mismatches      = 0;
  int          num_checks      = 0;
  int          cycles          = 0;
  logic [31:0] img_out [3]     = '{32'hFF, 32'h3A, 32'h25};
  logic [9:0]  img_in [3]      = '{10'h3FF, 10'h2A5, 10'h15A};

  always #2.5 clk_sys = ~clk_sys;

  mdsp_link_if mdsp_link_if_i ();
  mdsp_device mdsp_device_i (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .link            (mdsp_link_if_i),
    .in_pins         (in_pins),
    .out_overcurrent (out_overcurrent),
    .monitor_clear   (monitor_clear),
    .user_pwr_ok     (user_pwr_ok),
    .out_drive       (out_drive),
    .led_in_green    (led_in_green),
    .led_out_green   (led_out_green),
    .led_out_orange  (led_out_orange),
    .power_indicator (power_indicator)
  );
  mdsp_host mdsp_host_i (
    .clk_sys (clk_sys),
    .rst     (rst),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .link    (mdsp_link_if_i)
  );
  mdsp_sva mdsp_sva_i (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .frame       (mdsp_link_if_i.frame),
    .host_to_dev (mdsp_link_if_i.host_to_dev),
    .dev_to_host (mdsp_link_if_i.dev_to_host),
    .dev_fault   (mdsp_link_if_i.dev_fault)
  );

  // ********************
  // Tasks
  // ********************
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(rdata, exp);
    chk({31'h0, err}, 32'h0);
  endtask : rd

  task automatic run_frame();
    wr(MDSP_REG_CTRL, 32'h1);
    apb(1'b0, MDSP_REG_STATUS, 32'h0);
    chk(rdata & 32'h1, 32'h1);
    while (rdata[0] !== 1'b0) begin
      apb(1'b0, MDSP_REG_STATUS, 32'h0);
    end
    repeat (2) @(posedge clk_sys);
  endtask : run_frame

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  // ********************
  // Sequence
  // ********************
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(MDSP_REG_CTRL, 32'h0);
    rd(MDSP_REG_OUT_IMG, 32'h0);
    rd(MDSP_REG_STATUS, 32'h0);
    rd(MDSP_REG_IRQ_MASK, 32'h0);
    chk({26'h0, out_drive}, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdata, 32'h0);
    foreach (img_out[i]) begin
      in_pins <= img_in[i];
      wr(MDSP_REG_OUT_IMG, img_out[i]);
      rd(MDSP_REG_OUT_IMG, img_out[i] & 32'h3F);
      run_frame();
      rd(MDSP_REG_IN_IMG, {22'h0, img_in[i]});
      chk({26'h0, out_drive}, img_out[i] & 32'h3F);
      chk({26'h0, led_out_green}, img_out[i] & 32'h3F);
      chk({22'h0, led_in_green}, {22'h0, img_in[i]});
      chk({31'h0, power_indicator}, 32'h1);
    end
    // Output 0 trips while on; output 1 trips while off, which must not count.
    for (int k = 0; k < 2; k++) begin
      out_overcurrent <= 6'h03;
      @(posedge clk_sys);
      out_overcurrent <= 6'h00;
      repeat (2) @(posedge clk_sys);
      chk({26'h0, out_drive}, 32'h24);
      chk({26'h0, led_out_orange}, 32'h1);
      chk({31'h0, mdsp_link_if_i.dev_fault}, 32'h1);
      rd(MDSP_REG_STATUS, 32'h2);
      run_frame();
      chk({26'h0, out_drive}, 32'h24);
      if (k == 0) begin
        monitor_clear <= 1'b1;
      end else begin
        user_pwr_ok <= 1'b0;
      end
      @(posedge clk_sys);
      monitor_clear <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({26'h0, led_out_orange}, 32'h0);
      chk({31'h0, mdsp_link_if_i.dev_fault}, 32'h0);
      if (k == 1) begin
        chk({31'h0, power_indicator}, 32'h0);
        chk({22'h0, led_in_green}, 32'h15A);
        chk({26'h0, led_out_green}, 32'h25);
        user_pwr_ok <= 1'b1;
      end
      run_frame();
      chk({26'h0, out_drive}, 32'h25);
    end
    // Sticky status: frame done and fault events, masked and then cleared.
    rd(MDSP_REG_IRQ_STAT, 32'h9);
    chk({31'h0, irq}, 32'h0);
    wr(MDSP_REG_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(MDSP_REG_IRQ_STAT, 32'h9);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(MDSP_REG_IRQ_STAT, 32'h0);
    // A backplane power cycle is a reset, which must also drop a latched fault.
    out_overcurrent <= 6'h04;
    @(posedge clk_sys);
    out_overcurrent <= 6'h00;
    repeat (2) @(posedge clk_sys);
    chk({26'h0, led_out_orange}, 32'h4);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({26'h0, led_out_orange}, 32'h0);
    chk({31'h0, mdsp_link_if_i.dev_fault}, 32'h0);
    chk({26'h0, out_drive}, 32'h0);
    rd(MDSP_REG_IRQ_STAT, 32'h0);
    run_frame();
    rd(MDSP_REG_IN_IMG, 32'h15A);
    tally_and_finish();
  end
endmodule : mixed_discrete_io_serial_port_tb
`default_nettype wire
